// >>> verilog/rmlk_link.sv
// Radio modem link layer: AHB-Lite registers, packet framing, address filter and modem control
//
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "rmlk_map.svh"
module rmlk_link
   import rmlk_pkg::*;
#(
   parameter int MS_CYCLES = `RMLK_MS_CYC
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Serial data, terminal side
   input wire logic rxd,
   output logic txd,
   // Modem control
   output logic rts,
   output logic dtr,
   input wire logic cts,
   input wire logic dsr,
   input wire logic dcd,
   // Interrupt
   output logic irq
);
   // ==========================================================
   // Register state
   logic [`RMLK_CTRL_W-1:0] ctrl_r;
   rmlk_byte_t node_r;
   logic [15:0] div_r;
   rmlk_byte_t pretx_r;
   rmlk_byte_t tx_dst_r;
   rmlk_byte_t tx_cmd_r;
   logic [2:0] tx_len_r;
   rmlk_byte_t tx_data_r [0:3];
   logic [31:0] rx_hdr_r;
   logic [31:0] rx_data_r;
   logic [`RMLK_ST_W-1:0] status_r;
   logic [`RMLK_ST_W-1:0] mask_r;
   logic [`RMLK_ST_W-1:0] ev;
   logic wr_pend_r;
   logic [31:0] wr_addr_r;
   rmlk_tx_st_t tx_st_r;
   logic hs_mode;
   logic tx_start;

   assign hs_mode = ctrl_r[`RMLK_CTRL_HS];

   rmlk_ser_if ser ();
   assign ser.div = div_r;
   assign ser.par_en = ctrl_r[`RMLK_CTRL_PAR];
   assign ser.par_odd = ctrl_r[`RMLK_CTRL_ODD];
   assign ser.two_stop = ctrl_r[`RMLK_CTRL_STOP2];

   rmlk_uart u_uart (
      .ref_clk(ref_clk),
      .rst(rst),
      .ser(ser),
      .rxd(rxd),
      .txd(txd)
   );

   // ==========================================================
   // AHB-Lite slave: zero wait states, read data fetched in the address phase
   logic addr_ok;
   assign addr_ok = hsel && htrans[1] && hready;

   function automatic logic [31:0] rd_mux(input logic [31:0] a);
      unique case (a)
         `RMLK_OFS_CTRL: rd_mux = {26'h0, ctrl_r};
         `RMLK_OFS_NODE: rd_mux = {24'h0, node_r};
         `RMLK_OFS_BAUD: rd_mux = {16'h0, div_r};
         `RMLK_OFS_PRETX: rd_mux = {24'h0, pretx_r};
         `RMLK_OFS_TXHDR: rd_mux = {13'h0, tx_len_r, tx_cmd_r, tx_dst_r};
         `RMLK_OFS_TXDATA: rd_mux = {tx_data_r[3], tx_data_r[2], tx_data_r[1], tx_data_r[0]};
         `RMLK_OFS_RXHDR: rd_mux = rx_hdr_r;
         `RMLK_OFS_RXDATA: rd_mux = rx_data_r;
         `RMLK_OFS_STATUS: rd_mux = {26'h0, status_r};
         `RMLK_OFS_MASK: rd_mux = {26'h0, mask_r};
         `RMLK_OFS_LINE: rd_mux = {27'h0, tx_st_r != TX_IDLE, dcd, dsr, cts, rts};
         default: rd_mux = 32'h0000_0000;
      endcase
   endfunction

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_r <= 1'b0;
         wr_addr_r <= 32'h0000_0000;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_r <= addr_ok && hwrite;
         if (addr_ok) begin
            wr_addr_r <= haddr;
            hrdata <= hwrite ? 32'h0000_0000 : rd_mux(haddr);
         end
      end
   end

   function automatic logic wr_hit(input logic [31:0] ofs);
      return wr_pend_r && wr_addr_r == ofs;
   endfunction

   // ==========================================================
   // Configuration registers
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl_r <= `RMLK_CTRL_RST;
         node_r <= `RMLK_NODE_RST;
         div_r <= `RMLK_DIV_RST;
         pretx_r <= `RMLK_PRETX_RST;
         mask_r <= '0;
      end else begin
         if (wr_hit(`RMLK_OFS_CTRL)) begin
            ctrl_r <= hwdata[`RMLK_CTRL_W-1:0];
         end
         // Broadcast code is not a legal node address, so such a write is ignored
         if (wr_hit(`RMLK_OFS_NODE) && hwdata[7:0] != `RMLK_BCAST) begin
            node_r <= hwdata[7:0];
         end
         if (wr_hit(`RMLK_OFS_BAUD) && hwdata[15:0] != 16'h0000) begin
            div_r <= hwdata[15:0];
         end
         if (wr_hit(`RMLK_OFS_PRETX)) begin
            pretx_r <= hwdata[7:0];
         end
         if (wr_hit(`RMLK_OFS_MASK)) begin
            mask_r <= hwdata[`RMLK_ST_W-1:0];
         end
      end
   end

   // ==========================================================
   // Transmit request: a header write launches the packet
   logic last_bc_r;
   rmlk_byte_t last_src_r;
   logic rq_reply;
   logic rq_bad;
   rmlk_byte_t rq_dst;

   assign rq_reply = hwdata[8 + `RMLK_CMD_RPLY];
   assign rq_dst = rq_reply ? last_src_r : hwdata[7:0];
   // Reads to broadcast and replies to broadcast commands are refused
   assign rq_bad = (rq_dst == `RMLK_BCAST && !hwdata[8 + `RMLK_CMD_WR]) || (rq_reply && last_bc_r);
   assign tx_start = wr_hit(`RMLK_OFS_TXHDR) && tx_st_r == TX_IDLE && ctrl_r[`RMLK_CTRL_EN] && !rq_bad;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tx_dst_r <= 8'h00;
         tx_cmd_r <= 8'h00;
         tx_len_r <= 3'h0;
      end else if (tx_start) begin
         tx_dst_r <= rq_dst;
         tx_cmd_r <= hwdata[15:8];
         tx_len_r <= (hwdata[18:16] > `RMLK_MAX_DATA) ? `RMLK_MAX_DATA : hwdata[18:16];
      end
   end

   generate
      for (genvar g = 0; g < 4; g++) begin : g_txd
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               tx_data_r[g] <= 8'h00;
            end else if (wr_hit(`RMLK_OFS_TXDATA) && tx_st_r == TX_IDLE) begin
               tx_data_r[g] <= hwdata[8*g +: 8];
            end
         end
      end
   endgenerate

   // ==========================================================
   // Transmit sequencer
   logic [3:0] tx_idx_r;
   logic [3:0] tx_total;
   logic [15:0] ms_cnt_r;
   rmlk_byte_t ms_left_r;
   logic [15:0] tx_crc;
   logic tx_go;
   logic tx_in_crc;

   assign tx_total = `RMLK_HDR_BYTES + {1'b0, tx_len_r} + 4'h2;
   assign tx_in_crc = tx_idx_r >= tx_total - 4'h2;
   // With handshaking on, a dropped clear-to-send pauses between bytes
   assign tx_go = !hs_mode || (cts && dsr);
   assign ser.tx_valid = tx_st_r == TX_SEND && tx_go;

   always_comb begin
      ser.tx_data = 8'h00;
      if (tx_in_crc) begin
         ser.tx_data = (tx_idx_r == tx_total - 4'h2) ? tx_crc[7:0] : tx_crc[15:8];
      end else begin
         unique case (tx_idx_r)
            4'h0: ser.tx_data = tx_dst_r;
            4'h1: ser.tx_data = node_r;
            4'h2: ser.tx_data = tx_cmd_r;
            4'h3: ser.tx_data = {5'h00, tx_len_r};
            default: ser.tx_data = tx_data_r[tx_idx_r[1:0]];
         endcase
      end
   end

   rmlk_crc u_tx_crc (
      .ref_clk(ref_clk),
      .rst(rst),
      .clr(tx_start),
      .en(ser.tx_valid && ser.tx_ready && !tx_in_crc),
      .din(ser.tx_data),
      .crc(tx_crc)
   );

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tx_st_r <= TX_IDLE;
         tx_idx_r <= 4'h0;
         ms_cnt_r <= 16'h0000;
         ms_left_r <= 8'h00;
         rts <= 1'b0;
      end else begin
         unique case (tx_st_r)
            TX_IDLE: begin
               if (tx_start) begin
                  tx_st_r <= TX_RTS;
                  tx_idx_r <= 4'h0;
                  rts <= 1'b1;
               end
            end
            TX_RTS: begin
               if (tx_go) begin
                  tx_st_r <= (pretx_r == 8'h00) ? TX_SEND : TX_PRE;
                  ms_cnt_r <= 16'(MS_CYCLES - 1);
                  ms_left_r <= pretx_r;
               end
            end
            TX_PRE: begin
               if (ms_cnt_r != 16'h0000) begin
                  ms_cnt_r <= ms_cnt_r - 16'h0001;
               end else if (ms_left_r == 8'h01) begin
                  tx_st_r <= TX_SEND;
               end else begin
                  ms_cnt_r <= 16'(MS_CYCLES - 1);
                  ms_left_r <= ms_left_r - 8'h01;
               end
            end
            TX_SEND: begin
               if (ser.tx_valid && ser.tx_ready) begin
                  tx_idx_r <= tx_idx_r + 4'h1;
                  if (tx_idx_r == tx_total - 4'h1) begin
                     tx_st_r <= TX_DRAIN;
                  end
               end
            end
            TX_DRAIN: begin
               // Keep the request up until the last stop bit has left the line
               if (ser.tx_ready) begin
                  tx_st_r <= TX_IDLE;
                  rts <= 1'b0;
               end
            end
            default: tx_st_r <= TX_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Receive framing and address filter
   logic [3:0] rx_idx_r;
   rmlk_byte_t as_dst_r;
   rmlk_byte_t as_src_r;
   rmlk_byte_t as_cmd_r;
   logic [2:0] as_len_r;
   rmlk_byte_t as_data_r [0:3];
   logic rx_chk_r;
   logic [15:0] rx_crc;
   logic rx_last;
   logic rx_hit;

   assign rx_last = rx_idx_r == `RMLK_HDR_BYTES + {1'b0, as_len_r} + 4'h1;
   assign rx_hit = as_dst_r == node_r || as_dst_r == `RMLK_BCAST || ctrl_r[`RMLK_CTRL_PASS];

   rmlk_crc u_rx_crc (
      .ref_clk(ref_clk),
      .rst(rst),
      .clr(rx_idx_r == 4'h0),
      .en(ser.rx_valid && !ser.rx_err),
      .din(ser.rx_data),
      .crc(rx_crc)
   );

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rx_idx_r <= 4'h0;
         as_dst_r <= 8'h00;
         as_src_r <= 8'h00;
         as_cmd_r <= 8'h00;
         as_len_r <= 3'h0;
         rx_chk_r <= 1'b0;
      end else begin
         rx_chk_r <= 1'b0;
         if (ser.rx_valid) begin
            if (ser.rx_err || !ctrl_r[`RMLK_CTRL_EN]) begin
               rx_idx_r <= 4'h0;
            end else begin
               rx_idx_r <= rx_last && rx_idx_r >= `RMLK_HDR_BYTES ? 4'h0 : rx_idx_r + 4'h1;
               rx_chk_r <= rx_last && rx_idx_r >= `RMLK_HDR_BYTES;
               unique case (rx_idx_r)
                  4'h0: as_dst_r <= ser.rx_data;
                  4'h1: as_src_r <= ser.rx_data;
                  4'h2: as_cmd_r <= ser.rx_data;
                  4'h3: as_len_r <= ser.rx_data[2:0];
                  default: ;
               endcase
            end
         end
      end
   end

   generate
      for (genvar g = 0; g < 4; g++) begin : g_rxd
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               as_data_r[g] <= 8'h00;
            end else if (ser.rx_valid && rx_idx_r == `RMLK_HDR_BYTES + 4'(g) && 3'(g) < as_len_r) begin
               as_data_r[g] <= ser.rx_data;
            end
         end
      end
   endgenerate

   // Residue is zero when the appended checksum matches
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rx_hdr_r <= 32'h0000_0000;
         rx_data_r <= 32'h0000_0000;
         last_src_r <= 8'h00;
         last_bc_r <= 1'b0;
      end else if (rx_chk_r && rx_crc == 16'h0000 && rx_hit) begin
         rx_hdr_r <= {5'h00, as_len_r, as_cmd_r, as_src_r, as_dst_r};
         rx_data_r <= {as_data_r[3], as_data_r[2], as_data_r[1], as_data_r[0]};
         if (!as_cmd_r[`RMLK_CMD_RPLY]) begin
            last_src_r <= as_src_r;
            last_bc_r <= as_dst_r == `RMLK_BCAST;
         end
      end
   end

   // ==========================================================
   // Modem lines, events and interrupt
   logic dsr_d_r;

   always_comb begin
      ev = '0;
      ev[`RMLK_ST_TXDONE] = tx_st_r == TX_DRAIN && ser.tx_ready;
      ev[`RMLK_ST_RXOK] = rx_chk_r && rx_crc == 16'h0000 && rx_hit;
      ev[`RMLK_ST_CRCERR] = rx_chk_r && rx_crc != 16'h0000;
      ev[`RMLK_ST_LINEERR] = ser.rx_valid && ser.rx_err;
      ev[`RMLK_ST_LOST] = dsr_d_r && !dsr;
      ev[`RMLK_ST_REFUSE] = wr_hit(`RMLK_OFS_TXHDR) && !tx_start;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         dsr_d_r <= 1'b0;
         dtr <= 1'b0;
         status_r <= '0;
         irq <= 1'b0;
      end else begin
         dsr_d_r <= dsr;
         dtr <= ctrl_r[`RMLK_CTRL_EN];
         // A new event wins over a simultaneous write-one clear
         if (wr_hit(`RMLK_OFS_STATUS)) begin
            status_r <= (status_r & ~hwdata[`RMLK_ST_W-1:0]) | ev;
         end else begin
            status_r <= status_r | ev;
         end
         irq <= |((status_r | ev) & mask_r);
      end
   end
endmodule

// >>> verilog/rmlk_map.svh
// Address map, field positions, reset values and timing counts of the radio modem link layer
`ifndef RMLK_MAP_SVH
`define RMLK_MAP_SVH

// ==========================================================
// Register byte offsets
`define RMLK_OFS_CTRL 32'h0000_0000
`define RMLK_OFS_NODE 32'h0000_0004
`define RMLK_OFS_BAUD 32'h0000_0008
`define RMLK_OFS_PRETX 32'h0000_000c
`define RMLK_OFS_TXHDR 32'h0000_0010
`define RMLK_OFS_TXDATA 32'h0000_0014
`define RMLK_OFS_RXHDR 32'h0000_0018
`define RMLK_OFS_RXDATA 32'h0000_001c
`define RMLK_OFS_STATUS 32'h0000_0020
`define RMLK_OFS_MASK 32'h0000_0024
`define RMLK_OFS_LINE 32'h0000_0028

// ==========================================================
// Control fields
`define RMLK_CTRL_EN 0
`define RMLK_CTRL_HS 1
`define RMLK_CTRL_PAR 2
`define RMLK_CTRL_ODD 3
`define RMLK_CTRL_STOP2 4
`define RMLK_CTRL_PASS 5
`define RMLK_CTRL_W 6
`define RMLK_CTRL_RST 6'h00

// Command byte fields
`define RMLK_CMD_WR 0
`define RMLK_CMD_RPLY 6

// Status and mask bits
`define RMLK_ST_TXDONE 0
`define RMLK_ST_RXOK 1
`define RMLK_ST_CRCERR 2
`define RMLK_ST_LINEERR 3
`define RMLK_ST_LOST 4
`define RMLK_ST_REFUSE 5
`define RMLK_ST_W 6

// ==========================================================
// Addresses and packet layout
`define RMLK_BCAST 8'hff
`define RMLK_NODE_RST 8'h00
`define RMLK_HDR_BYTES 4'h4
`define RMLK_MAX_DATA 3'h4
`define RMLK_CRC_INIT 16'h0000
`define RMLK_CRC_POLY 16'ha001

// ==========================================================
// Timing
`define RMLK_CLK_HZ 10000000
`define RMLK_BAUD_DEF 19200
`define RMLK_DIV_RST 16'((`RMLK_CLK_HZ + `RMLK_BAUD_DEF / 2) / `RMLK_BAUD_DEF)
`define RMLK_PRETX_UNIT_US 1000
`define RMLK_MS_CYC (`RMLK_CLK_HZ / 1000000 * `RMLK_PRETX_UNIT_US)
`define RMLK_PRETX_RST 8'h00

`endif

// >>> verilog/rmlk_pkg.sv
// Types shared by the radio modem link layer
package rmlk_pkg;
   typedef logic [7:0] rmlk_byte_t;
   typedef enum logic [2:0] {
      TX_IDLE  = 3'b000,
      TX_RTS   = 3'b001,
      TX_PRE   = 3'b010,
      TX_SEND  = 3'b011,
      TX_DRAIN = 3'b100
   } rmlk_tx_st_t;
endpackage

// >>> verilog/rmlk_ser_if.sv
// Byte stream and line settings between the link controller and its serial engine
`timescale 1ns/1ps
interface rmlk_ser_if;
   import rmlk_pkg::*;
   rmlk_byte_t tx_data;
   logic tx_valid;
   logic tx_ready;
   rmlk_byte_t rx_data;
   logic rx_valid;
   logic rx_err;
   logic [15:0] div;
   logic par_en;
   logic par_odd;
   logic two_stop;
   modport ctl (output tx_data, tx_valid, div, par_en, par_odd, two_stop,
                input tx_ready, rx_data, rx_valid, rx_err);
   modport phy (input tx_data, tx_valid, div, par_en, par_odd, two_stop,
                output tx_ready, rx_data, rx_valid, rx_err);
endinterface

// >>> verilog/rmlk_crc.sv
// Byte-wise reflected CRC-16 accumulator
`timescale 1ns/1ps
`include "rmlk_map.svh"
module rmlk_crc
   import rmlk_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Byte feed
   input wire logic clr,
   input wire logic en,
   input wire rmlk_byte_t din,
   // Running value
   output logic [15:0] crc
);
   function automatic logic [15:0] crc_byte(input logic [15:0] c, input rmlk_byte_t d);
      logic [15:0] v;
      v = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++) begin
         v = v[0] ? ((v >> 1) ^ `RMLK_CRC_POLY) : (v >> 1);
      end
      return v;
   endfunction

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         crc <= `RMLK_CRC_INIT;
      end else if (clr) begin
         crc <= en ? crc_byte(`RMLK_CRC_INIT, din) : `RMLK_CRC_INIT;
      end else if (en) begin
         crc <= crc_byte(crc, din);
      end
   end
endmodule

// >>> verilog/rmlk_uart.sv
// Asynchronous serial engine with selectable parity and stop bits
`timescale 1ns/1ps
`include "rmlk_map.svh"
module rmlk_uart
   import rmlk_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Controller side
   rmlk_ser_if.phy ser,
   // Line
   input wire logic rxd,
   output logic txd
);
   // ==========================================================
   // Transmitter
   logic tx_busy_r;
   logic [15:0] tx_cnt_r;
   logic [3:0] tx_bit_r;
   logic [3:0] tx_last_r;
   logic [11:0] tx_sh_r;
   logic tx_par;

   assign tx_par = (^ser.tx_data) ^ ser.par_odd;
   assign ser.tx_ready = !tx_busy_r;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tx_busy_r <= 1'b0;
         tx_cnt_r <= 16'h0000;
         tx_bit_r <= 4'h0;
         tx_last_r <= 4'h0;
         tx_sh_r <= 12'hfff;
         txd <= 1'b1;
      end else if (!tx_busy_r) begin
         if (ser.tx_valid) begin
            tx_busy_r <= 1'b1;
            tx_cnt_r <= ser.div - 16'h0001;
            tx_bit_r <= 4'h0;
            tx_last_r <= 4'h9 + {3'b000, ser.par_en} + {3'b000, ser.two_stop};
            tx_sh_r <= ser.par_en ? {2'b11, tx_par, ser.tx_data, 1'b0} : {3'b111, ser.tx_data, 1'b0};
            txd <= 1'b0;
         end
      end else if (tx_cnt_r != 16'h0000) begin
         tx_cnt_r <= tx_cnt_r - 16'h0001;
      end else if (tx_bit_r == tx_last_r) begin
         tx_busy_r <= 1'b0;
         txd <= 1'b1;
      end else begin
         tx_cnt_r <= ser.div - 16'h0001;
         tx_bit_r <= tx_bit_r + 4'h1;
         tx_sh_r <= {1'b1, tx_sh_r[11:1]};
         txd <= tx_sh_r[1];
      end
   end

   // ==========================================================
   // Receiver, sampling each bit at its centre
   logic rx_busy_r;
   logic [15:0] rx_cnt_r;
   logic [3:0] rx_bit_r;
   logic [7:0] rx_sh_r;
   logic rx_bad_r;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rx_busy_r <= 1'b0;
         rx_cnt_r <= 16'h0000;
         rx_bit_r <= 4'h0;
         rx_sh_r <= 8'h00;
         rx_bad_r <= 1'b0;
         ser.rx_valid <= 1'b0;
         ser.rx_err <= 1'b0;
         ser.rx_data <= 8'h00;
      end else begin
         ser.rx_valid <= 1'b0;
         if (!rx_busy_r) begin
            if (!rxd) begin
               rx_busy_r <= 1'b1;
               rx_cnt_r <= {1'b0, ser.div[15:1]};
               rx_bit_r <= 4'h0;
               rx_bad_r <= 1'b0;
            end
         end else if (rx_cnt_r != 16'h0000) begin
            rx_cnt_r <= rx_cnt_r - 16'h0001;
         end else begin
            rx_cnt_r <= ser.div - 16'h0001;
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r == 4'h0) begin
               // A glitch shorter than half a bit is not a start bit
               rx_busy_r <= !rxd;
            end else if (rx_bit_r < 4'h9) begin
               rx_sh_r <= {rxd, rx_sh_r[7:1]};
            end else if (rx_bit_r == 4'h9 && ser.par_en) begin
               rx_bad_r <= (rxd ^ (^rx_sh_r)) != ser.par_odd;
            end else begin
               // Only the first stop bit is checked so back-to-back bytes are not lost
               rx_busy_r <= 1'b0;
               ser.rx_valid <= 1'b1;
               ser.rx_err <= rx_bad_r | !rxd;
               ser.rx_data <= rx_sh_r;
            end
         end
      end
   end
endmodule

// >>> sim/rmlk_link_monitor.sv
// Bus and modem-line checks of the link layer
`timescale 1ns/1ps
module rmlk_link_monitor (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // Line and interrupt
   input wire logic txd,
   input wire logic rts,
   input wire logic dtr,
   input wire logic irq
);
   logic wdp_r;
   wire logic tk = hsel && htrans[1] && hready;
   // Write data phase marker: dtr may only move, and rts may only rise, as a result of one
   always_ff @(posedge ref_clk) wdp_r <= tk && hwrite && !rst;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // ========
   // Checks
   AST_RDY: assert property (hreadyout) else $error("wait state");
   AST_OKAY: assert property (!hresp) else $error("error response");
   AST_RST: assert property (disable iff (1'b0) rst |=> !rts && !dtr && !irq && txd)
      else $error("bad reset state");
   AST_HOLD: assert property (!tk |=> $stable(hrdata)) else $error("read data moved");
   AST_DTR: assert property ($changed(dtr) |-> $past(wdp_r) || $past(wdp_r, 2) || $past(wdp_r, 3))
      else $error("dtr moved alone");
   AST_RTS: assert property ($rose(rts) |-> $past(wdp_r) || $past(wdp_r, 2) || $past(wdp_r, 3))
      else $error("rts rose alone");
   AST_RTS_DTR: assert property ($rose(rts) |-> dtr) else $error("send while not ready");
   AST_IDLE: assert property (!rts |-> txd) else $error("data without rts");
   COV_TX: cover property ($rose(rts));
   COV_IRQ: cover property ($rose(irq));
   COV_CLR: cover property ($fell(irq));
endmodule

bind rmlk_link rmlk_link_monitor rmlk_link_monitor_i (.ref_clk, .rst, .hsel, .htrans, .hwrite, .hready,
   .hrdata, .hreadyout, .hresp, .txd, .rts, .dtr, .irq);

// >>> sim/rmlk_modem.sv
// Radio modem model on the far side of the serial port
`timescale 1ns/1ps
module rmlk_modem (
   // Clock
   input wire logic ref_clk,
   // Terminal side
   input wire logic rts,
   input wire logic txd,
   output logic cts,
   output logic dsr,
   output logic dcd,
   output logic rxd,
   // Bench control
   input wire logic cts_hold,
   input wire logic dsr_on
);
   logic [2:0] key_r = 3'h0;
   // Keying the radio takes time, so clear-to-send lags the request
   always_ff @(posedge ref_clk) key_r <= {key_r[1:0], rts};
   assign cts = key_r[2] && !cts_hold;
   assign dsr = dsr_on;
   assign dcd = key_r[2];
   // Common channel: every frame sent is heard back whole, CRC included
   always_ff @(posedge ref_clk) rxd <= txd;
endmodule

// >>> sim/rmlk_link_tb_top.sv
// Self-checking bench of the radio modem link layer
`timescale 1ns/1ps
`include "rmlk_map.svh"
module rmlk_link_tb_top;
   logic ref_clk = 0, rst = 1, hsel = 0, hwrite = 0, cts_hold = 0, dsr_on = 1;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic hreadyout, hresp, txd, rxd, rts, dtr, cts, dsr, dcd, irq;
   int fails = 0, compares = 0;
   always #50 ref_clk = ~ref_clk;
   rmlk_link #(.MS_CYCLES(20)) rmlk_link_i (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rxd, .txd,
      .rts, .dtr, .cts, .dsr, .dcd, .irq);
   rmlk_modem rmlk_modem_i (.ref_clk, .rts, .txd, .cts, .dsr, .dcd, .rxd, .cts_hold, .dsr_on);
   // ========
   // Helpers
   task automatic results;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a, d);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, d);
      bus(1'b1, a, d);
   endtask
   task automatic rdc(input logic [31:0] a, exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic tx(input logic [7:0] dst);
      wr(`RMLK_OFS_TXDATA, 32'h44332211);
      wr(`RMLK_OFS_TXHDR, {13'h0, 3'h2, 8'h01, dst});
   endtask
   // Receiver ends within two bit times of the sender's last stop bit
   task automatic fin(input logic [31:0] exp);
      for (int i = 0; i < 4000 && irq !== 1'b1; i++) @(posedge ref_clk);
      repeat (16) @(posedge ref_clk);
      rdc(`RMLK_OFS_STATUS, exp);
      wr(`RMLK_OFS_STATUS, 32'h3f);
   endtask
   // ========
   // Scenarios
   task automatic t_reset;
      logic [31:0] e[7] = '{32'h0, 32'h0, 32'h209, 32'h0, 32'h0, 32'h0, 32'h0};
      wr(32'h2c, 32'hffff_ffff);
      for (int i = 0; i < 7; i++) rdc(32'(i * 4 + (i > 3 ? 16 : 0) + (i > 5 ? 4 : 0)), e[i]);
   endtask
   task automatic t_setup;
      wr(`RMLK_OFS_NODE, 32'hff);
      rdc(`RMLK_OFS_NODE, 32'h0);
      wr(`RMLK_OFS_NODE, 32'hfe);
      rdc(`RMLK_OFS_NODE, 32'hfe);
      tx(8'h05);
      rdc(`RMLK_OFS_STATUS, 32'h20);
      wr(`RMLK_OFS_STATUS, 32'h20);
      wr(`RMLK_OFS_NODE, 32'h05);
      wr(`RMLK_OFS_BAUD, 32'h8);
      wr(`RMLK_OFS_MASK, 32'h1);
      wr(`RMLK_OFS_CTRL, 32'h1);
      wr(`RMLK_OFS_TXHDR, {13'h0, 3'h2, 8'h00, 8'hff});
      rdc(`RMLK_OFS_STATUS, 32'h20);
      wr(`RMLK_OFS_STATUS, 32'h20);
      rdc(`RMLK_OFS_STATUS, 32'h0);
   endtask
   task automatic t_frames;
      tx(8'h05);
      fin(32'h3);
      rdc(`RMLK_OFS_RXHDR, 32'h0201_0505);
      rdc(`RMLK_OFS_RXDATA, 32'h0000_2211);
      tx(8'h07);
      fin(32'h1);
      tx(8'hff);
      fin(32'h3);
      rdc(`RMLK_OFS_RXHDR, 32'h0201_05ff);
   endtask
   // Reply after a broadcast is refused; after a plain command it goes to the source
   task automatic t_opts;
      wr(`RMLK_OFS_TXHDR, {13'h0, 3'h0, 8'h41, 8'h33});
      rdc(`RMLK_OFS_STATUS, 32'h20);
      wr(`RMLK_OFS_STATUS, 32'h20);
      wr(`RMLK_OFS_CTRL, 32'h1d);
      tx(8'h05);
      fin(32'h3);
      wr(`RMLK_OFS_CTRL, 32'h21);
      wr(`RMLK_OFS_TXHDR, {13'h0, 3'h0, 8'h41, 8'h33});
      fin(32'h3);
      rdc(`RMLK_OFS_RXHDR, 32'h0041_0505);
      tx(8'h07);
      fin(32'h3);
      rdc(`RMLK_OFS_RXHDR, 32'h0201_0507);
   endtask
   task automatic t_hs;
      int n;
      wr(`RMLK_OFS_CTRL, 32'h3);
      wr(`RMLK_OFS_PRETX, 32'h1);
      cts_hold <= 1'b1;
      tx(8'h07);
      n = 0;
      repeat (100) @(posedge ref_clk) n += int'(txd !== 1'b1);
      chk(32'(n), 32'h0);
      chk({31'h0, rts}, 32'h1);
      chk({31'h0, dtr}, 32'h1);
      rdc(`RMLK_OFS_LINE, 32'h1d);
      cts_hold <= 1'b0;
      n = 0;
      while (txd === 1'b1 && n < 500) begin
         @(posedge ref_clk);
         n++;
      end
      chk(32'(n >= 20), 32'h1);
      fin(32'h1);
      wr(`RMLK_OFS_CTRL, 32'h1);
      cts_hold <= 1'b1;
      tx(8'h07);
      fin(32'h1);
      cts_hold <= 1'b0;
   endtask
   task automatic t_lost;
      wr(`RMLK_OFS_MASK, 32'h10);
      dsr_on <= 1'b0;
      for (int i = 0; i < 20 && irq !== 1'b1; i++) @(posedge ref_clk);
      chk({31'h0, irq}, 32'h1);
      rdc(`RMLK_OFS_STATUS, 32'h10);
      wr(`RMLK_OFS_MASK, 32'h0);
      repeat (3) @(posedge ref_clk);
      chk({31'h0, irq}, 32'h0);
      wr(`RMLK_OFS_STATUS, 32'h10);
      rdc(`RMLK_OFS_STATUS, 32'h0);
      dsr_on <= 1'b1;
   endtask
   initial begin
      #3000000;
      fails++;
      results();
   end
   initial begin
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset();
      t_setup();
      t_frames();
      t_opts();
      t_hs();
      t_lost();
      results();
   end
endmodule
